/* File: hw/sie_pkg.sv */
/*
  constants, register map and state types for the small sfr bank that holds
  the extra interrupt enables, the comparator pin input disables and the two
  arithmetic registers.
  assumes a single core clock and an asynchronous active-low system reset.
*/
// Notes on behaviour
// - brownout request passes only while enable bit 6
// - pwm underflow request passes only while bit 5
// - watchdog request passes only while bit 4
// - bit 1 disables negative comparator pin input
// - primary arithmetic register at E0h, read/write
// - secondary arithmetic register at F0h, read/write
package sie_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] SIE_ADDR_PRIMARY = 8'hE0;  // primary arithmetic
  localparam logic [7:0] SIE_ADDR_PINDIS = 8'hE6;   // comparator pin digital disable
  localparam logic [7:0] SIE_ADDR_IRQEN = 8'hE8;    // extra interrupt enable
  localparam logic [7:0] SIE_ADDR_SECOND = 8'hF0;   // secondary arithmetic
  localparam logic [7:0] SIE_ADDR_STATUS = 8'hF4;   // sticky event status, write one clears
  localparam logic [7:0] SIE_ADDR_MASK = 8'hF5;     // interrupt mask, same layout as status

  // ****************************************************************
  // field positions and writable masks
  // ****************************************************************
  localparam int SIE_BIT_BOV = 6;   // brownout enable / status
  localparam int SIE_BIT_PWM = 5;   // pwm underflow enable / status
  localparam int SIE_BIT_WDT = 4;   // watchdog enable / status
  localparam int SIE_BIT_NEG = 1;   // negative comparator pin disable
  localparam int SIE_BIT_POS = 0;   // positive comparator pin disable
  localparam int SIE_EVT_LO = 4;    // lowest event bit
  localparam int SIE_EVT_NUM = 3;   // number of event bits
  localparam logic [7:0] SIE_IRQ_WMASK = 8'h70;  // bits 6..4 only
  localparam logic [7:0] SIE_PIN_WMASK = 8'h03;  // bits 1..0 only

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] SIE_RST_BYTE = 8'h00;   // every register clears
  localparam logic SIE_RST_BIT = 1'b0;

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] primaryArith;  // main operand / result
    logic [7:0] secondArith;   // second accumulator
    logic [7:0] pinDisable;    // only bits 1..0 ever set
    logic [7:0] irqEnable;     // only bits 6..4 ever set
    logic [7:0] irqMask;       // only bits 6..4 ever set
    logic [7:0] readData;      // read answer, one cycle
    logic [2:0] fwdReq;        // gated requests: 2 bov, 1 pwm, 0 wdt
    logic irqOut;              // level interrupt
  } sie_state_t;

  typedef struct packed {
    logic flag;  // sticky event
  } sie_flag_t;

endpackage : sie_pkg

/* File: hw/sie_sticky_bit.sv */
/*
  one sticky status flag: set by a hardware event, cleared by software.
  assumes set and clear are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module sie_sticky_bit
  import sie_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic setEvent,
  input wire logic clearEvent,
  // state
  output logic flagOut
);

  sie_flag_t cur;  // registered flag
  sie_flag_t next_cur;  // next flag

  // ****************************************************************
  // next state: the set wins, so an event during a clear is kept
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.flag = (cur.flag & ~clearEvent) | setEvent;
  end

  // register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{flag: SIE_RST_BIT};
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // an event in the cycle of a clear still leaves the flag set
  property p_set_wins;
    @(posedge clk_sys) disable iff (!arst_n) setEvent |=> flagOut;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a clear");

  assign flagOut = cur.flag;

endmodule : sie_sticky_bit

/* File: hw/sie_bank.sv */
/*
  sfr bank: extra interrupt enables gating three interrupt requests, the
  comparator pin digital input disables, the primary and secondary
  arithmetic registers, and a sticky status / mask pair with one interrupt.
  assumes a register master that issues one-cycle read or write strobes,
  never both at once, and takes read data in the cycle after a read.
*/
`timescale 1ns/1ps
module sie_bank
  import sie_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // raw interrupt requests from the sources
  input wire logic brownoutReq,
  input wire logic pwmUnderflowReq,
  input wire logic watchdogReq,
  // gated requests toward the interrupt logic
  output logic brownoutIrqFwd,
  output logic pwmUnderflowIrqFwd,
  output logic watchdogIrqFwd,
  // comparator pin input control
  output logic negativeInputDigitalDisable,
  output logic positiveInputDigitalDisable,
  // arithmetic register contents toward the core
  output logic [7:0] primaryArithValue,
  output logic [7:0] secondArithValue,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sie_state_t cur;       // registered state except the sticky flags
  sie_state_t next_cur;  // next state
  logic [7:0] statusByte;  // sticky flags placed at bits 6..4
  logic [2:0] statusBits;  // flags from the sticky cells
  logic [2:0] statusClear;  // write-one-to-clear per flag
  logic wrPrimary;  // write strobes per register
  logic wrSecond;
  logic wrPinDis;
  logic wrIrqEn;
  logic wrStatus;
  logic wrMask;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // unmapped writes are dropped, unmapped reads answer zero
  always_comb begin
    wrPrimary = regWrite && (regAddr == SIE_ADDR_PRIMARY);
    wrSecond = regWrite && (regAddr == SIE_ADDR_SECOND);
    wrPinDis = regWrite && (regAddr == SIE_ADDR_PINDIS);
    wrIrqEn = regWrite && (regAddr == SIE_ADDR_IRQEN);
    wrStatus = regWrite && (regAddr == SIE_ADDR_STATUS);
    wrMask = regWrite && (regAddr == SIE_ADDR_MASK);
  end

  // clear pattern taken from the written byte, same layout as status
  always_comb begin
    statusClear = wrStatus ? regWdata[SIE_EVT_LO +: SIE_EVT_NUM] : 3'h0;
    statusByte = SIE_RST_BYTE;
    statusByte[SIE_EVT_LO +: SIE_EVT_NUM] = statusBits;
  end

  // ****************************************************************
  // sticky status flags, one cell per event
  // ****************************************************************
  // the forwarded request of the same bit sets each flag, so a masked
  // off source (enable clear) never shows in status either
  genvar gi;
  generate
    for (gi = 0; gi < SIE_EVT_NUM; gi++) begin : g_flag
      sie_sticky_bit u_flag (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .setEvent(cur.fwdReq[gi]),
        .clearEvent(statusClear[gi]),
        .flagOut(statusBits[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_cur = cur;

    // arithmetic registers take the whole byte
    if (wrPrimary) begin
      next_cur.primaryArith = regWdata;
    end
    if (wrSecond) begin
      next_cur.secondArith = regWdata;
    end

    // reserved positions never store, so they read back zero
    if (wrPinDis) begin
      next_cur.pinDisable = regWdata & SIE_PIN_WMASK;
    end
    if (wrIrqEn) begin
      next_cur.irqEnable = regWdata & SIE_IRQ_WMASK;
    end
    if (wrMask) begin
      next_cur.irqMask = regWdata & SIE_IRQ_WMASK;
    end

    // request gating: a cleared enable blocks the source outright
    next_cur.fwdReq[2] = brownoutReq & cur.irqEnable[SIE_BIT_BOV];
    next_cur.fwdReq[1] = pwmUnderflowReq & cur.irqEnable[SIE_BIT_PWM];
    next_cur.fwdReq[0] = watchdogReq & cur.irqEnable[SIE_BIT_WDT];

    // level interrupt while any unmasked flag is set
    next_cur.irqOut = |(statusByte & cur.irqMask);

    // read answer stands only in the cycle after the strobe
    next_cur.readData = SIE_RST_BYTE;
    if (regRead) begin
      case (regAddr)
        SIE_ADDR_PRIMARY: next_cur.readData = cur.primaryArith;
        SIE_ADDR_SECOND: next_cur.readData = cur.secondArith;
        SIE_ADDR_PINDIS: next_cur.readData = cur.pinDisable;
        SIE_ADDR_IRQEN: next_cur.readData = cur.irqEnable;
        SIE_ADDR_STATUS: next_cur.readData = statusByte;
        SIE_ADDR_MASK: next_cur.readData = cur.irqMask;
        default: next_cur.readData = SIE_RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{primaryArith: SIE_RST_BYTE, secondArith: SIE_RST_BYTE,
               pinDisable: SIE_RST_BYTE, irqEnable: SIE_RST_BYTE,
               irqMask: SIE_RST_BYTE, readData: SIE_RST_BYTE,
               fwdReq: 3'h0, irqOut: SIE_RST_BIT};
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign regRdata = cur.readData;
  assign brownoutIrqFwd = cur.fwdReq[2];
  assign pwmUnderflowIrqFwd = cur.fwdReq[1];
  assign watchdogIrqFwd = cur.fwdReq[0];
  // a set bit cuts the digital path; analog path to the comparator stays
  assign negativeInputDigitalDisable = cur.pinDisable[SIE_BIT_NEG];
  assign positiveInputDigitalDisable = cur.pinDisable[SIE_BIT_POS];
  assign primaryArithValue = cur.primaryArith;
  assign secondArithValue = cur.secondArith;
  assign irq = cur.irqOut;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // brownout forwarded exactly when request met the enable
  property p_bov_gate;
    ##1 (brownoutIrqFwd == $past(brownoutReq && cur.irqEnable[SIE_BIT_BOV]));
  endproperty
  a_bov_gate: assert property (p_bov_gate) else $error("brownout gate wrong");

  // pwm underflow blocked two cycles after the enable is written zero, if no enable write follows
  property p_pwm_block;
    (wrIrqEn && !regWdata[SIE_BIT_PWM]) ##1 !wrIrqEn |=> !pwmUnderflowIrqFwd;
  endproperty
  a_pwm_block: assert property (p_pwm_block) else $error("pwm passed while off");

  // watchdog passes one cycle after a request with the enable set
  property p_wdt_pass;
    (watchdogReq && cur.irqEnable[SIE_BIT_WDT]) |=> watchdogIrqFwd;
  endproperty
  a_wdt_pass: assert property (p_wdt_pass) else $error("watchdog not forwarded");

  // negative pin disable follows a write of bit 1
  property p_neg_dis;
    wrPinDis |=> (negativeInputDigitalDisable == $past(regWdata[SIE_BIT_NEG]));
  endproperty
  a_neg_dis: assert property (p_neg_dis) else $error("pin disable wrong");

  // primary register reads back what was written
  property p_primary_rw;
    logic [7:0] v;
    (wrPrimary, v = regWdata) ##1 (regRead && regAddr == SIE_ADDR_PRIMARY
      && !regWrite) |=> (regRdata == v);
  endproperty
  a_primary_rw: assert property (p_primary_rw) else $error("primary readback");

  // secondary register reads back what was written
  property p_second_rw;
    logic [7:0] v;
    (wrSecond, v = regWdata) ##1 (regRead && regAddr == SIE_ADDR_SECOND
      && !regWrite) |=> (regRdata == v);
  endproperty
  a_second_rw: assert property (p_second_rw) else $error("secondary readback");

  // reserved bits of the enable register read as zero
  property p_irqen_rsv;
    (regRead && regAddr == SIE_ADDR_IRQEN) |=> ((regRdata & ~SIE_IRQ_WMASK) == 8'h00);
  endproperty
  a_irqen_rsv: assert property (p_irqen_rsv) else $error("enable reserved set");

  // reserved bits of the pin disable register read as zero
  property p_pindis_rsv;
    (regRead && regAddr == SIE_ADDR_PINDIS) |=> ((regRdata & ~SIE_PIN_WMASK) == 8'h00);
  endproperty
  a_pindis_rsv: assert property (p_pindis_rsv) else $error("pin reserved set");

  // interrupt follows masked status one cycle later
  property p_irq_level;
    ##1 (irq == $past(|(statusByte & cur.irqMask)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  // read data is zero when no read was made
  property p_rd_idle;
    !regRead |=> (regRdata == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  // pwm underflow passes one cycle after a request with the enable set
  property p_pwm_pass;
    (pwmUnderflowReq && cur.irqEnable[SIE_BIT_PWM]) |=> pwmUnderflowIrqFwd;
  endproperty
  a_pwm_pass: assert property (p_pwm_pass) else $error("pwm not forwarded");

  // a cleared watchdog enable keeps the forwarded request low
  property p_wdt_block;
    !cur.irqEnable[SIE_BIT_WDT] |=> !watchdogIrqFwd;
  endproperty
  a_wdt_block: assert property (p_wdt_block) else $error("watchdog passed while off");

  // an enable write keeps only the three defined bits
  property p_irqen_store;
    wrIrqEn |=> (cur.irqEnable == ($past(regWdata) & SIE_IRQ_WMASK));
  endproperty
  a_irqen_store: assert property (p_irqen_store) else $error("enable store wrong");

  // the positive pin disable follows a write of bit 0
  property p_pos_dis;
    wrPinDis |=> (positiveInputDigitalDisable == $past(regWdata[SIE_BIT_POS]));
  endproperty
  a_pos_dis: assert property (p_pos_dis) else $error("positive pin disable wrong");

  // main scenarios
  c_bov_fwd: cover property (brownoutIrqFwd);
  // the flag drops one edge after the clear, the level one edge later
  c_irq: cover property (irq ##1 wrStatus ##2 !irq);
  c_primary: cover property (wrPrimary ##1 regRead && regAddr == SIE_ADDR_PRIMARY);
  c_neg_dis: cover property (negativeInputDigitalDisable);

endmodule : sie_bank

/* File: verif/sie_bank_tb.sv */
/*
  self-checking bench for the sfr bank: register access, reserved bits,
  request gating by the enable bits, sticky status, mask and interrupt.
  assumes the bank from hw/ and its package; one 25 MHz clock, no partner.
*/
`timescale 1ns/1ps
module sie_bank_tb;
  import sie_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk_sys;           // core clock
  logic arst_n;            // async reset, active low
  logic [7:0] regAddr;     // register port address
  logic [7:0] regWdata;    // write data
  logic regWrite;          // write strobe
  logic regRead;           // read strobe
  logic [7:0] regRdata;    // read answer
  logic [2:0] rawReq;      // raw requests: 2 brownout, 1 pwm, 0 watchdog
  logic [2:0] fwd;         // gated requests, same order
  logic negDis;            // negative pin digital disable
  logic posDis;            // positive pin digital disable
  logic [7:0] primVal;     // primary arithmetic content
  logic [7:0] secVal;      // secondary arithmetic content
  logic irq;               // level interrupt
  int error_cnt;           // mismatches seen
  int n_compared;          // comparisons made
  logic [7:0] rdv;         // last read value
  logic [7:0] en;          // enable byte under test
  logic [7:0] msk;         // mask byte under test
  logic [7:0] dat;         // random data byte
  logic [2:0] rq;          // request pattern under test

  sie_bank u_sie_bank (
    .clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .brownoutReq(rawReq[2]), .pwmUnderflowReq(rawReq[1]), .watchdogReq(rawReq[0]),
    .brownoutIrqFwd(fwd[2]), .pwmUnderflowIrqFwd(fwd[1]), .watchdogIrqFwd(fwd[0]),
    .negativeInputDigitalDisable(negDis), .positiveInputDigitalDisable(posDis),
    .primaryArithValue(primVal), .secondArithValue(secVal), .irq(irq)
  );

  // ****************************************************************
  // clock and helpers
  // ****************************************************************
  // free running clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // compare with case equality so an unknown never matches
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // one-cycle write; a clock edge passes before the next strobe rises
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  // one-cycle read; data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // write then read the same address with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 q = regRdata;
  endtask : wr_rd

  // status expected after a pulse: only enabled sources leave a flag
  function automatic logic [7:0] exp_status(input logic [7:0] e, input logic [2:0] r);
    return {1'b0, r & e[6:4], 4'h0};
  endfunction : exp_status

  // verdict in one place, reached by the tests and by the watchdog
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // watchdog: the tests need under 500 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("mismatch at %0t: run did not complete", $time);
    finish_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    error_cnt = 0;
    n_compared = 0;
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    rawReq = 3'h0;
    void'($urandom(32'hD807322A));
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    // primary, secondary and enable registers read zero out of reset
    rd(SIE_ADDR_PRIMARY, rdv);
    chk(rdv, 8'h00, "primary reset");
    rd(SIE_ADDR_SECOND, rdv);
    chk(rdv, 8'h00, "second reset");
    rd(SIE_ADDR_IRQEN, rdv);
    chk(rdv, 8'h00, "enable reset");
    chk(8'(negDis), 8'h00, "negative disable reset");
    // arithmetic registers: random data plus all-ones and all-zeros
    for (int i = 0; i < 8; i++) begin
      dat = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      // a read right behind a write must already see the new byte
      wr_rd(SIE_ADDR_PRIMARY, ~dat, rdv);
      chk(rdv, ~dat, "primary back to back");
      wr_rd(SIE_ADDR_SECOND, dat, rdv);
      chk(rdv, dat, "second back to back");
      wr(SIE_ADDR_PRIMARY, dat);
      #1 chk(primVal, dat, "primary value");
      wr(SIE_ADDR_SECOND, ~dat);
      #1 chk(secVal, ~dat, "second value");
      rd(SIE_ADDR_PRIMARY, rdv);
      chk(rdv, dat, "primary read");
      rd(SIE_ADDR_SECOND, rdv);
      chk(rdv, ~dat, "second read");
    end
    // unmapped address neighbours the pin register and changes nothing
    wr(8'hE7, 8'hFF);
    rd(8'hE7, rdv);
    chk(rdv, 8'h00, "unmapped read");
    rd(SIE_ADDR_PRIMARY, rdv);
    chk(rdv, dat, "primary kept");
    // pin disable: only bits 1..0 stick, bit 1 drives the negative pin
    for (int i = 0; i < 6; i++) begin
      dat = (i == 0) ? 8'hFF : (i == 1) ? 8'hFC : 8'($urandom);
      wr(SIE_ADDR_PINDIS, dat);
      #1 chk(8'(negDis), 8'(dat[1]), "negative disable");
      chk(8'(posDis), 8'(dat[0]), "positive disable");
      rd(SIE_ADDR_PINDIS, rdv);
      chk(rdv, dat & 8'h03, "pin disable read");
    end
    // gating, sticky status, mask and interrupt; corner cases first
    for (int i = 0; i < 16; i++) begin
      en = (i == 0) ? 8'hFF : (i == 1) ? 8'h8F : 8'($urandom);
      msk = (i < 2) ? 8'hFF : 8'($urandom);
      rq = (i < 2) ? 3'h7 : 3'($urandom);
      wr(SIE_ADDR_IRQEN, en);
      wr(SIE_ADDR_MASK, msk);
      wr(SIE_ADDR_STATUS, 8'hFF);
      rd(SIE_ADDR_IRQEN, rdv);
      chk(rdv, en & 8'h70, "enable read");
      rd(SIE_ADDR_MASK, rdv);
      chk(rdv, msk & 8'h70, "mask read");
      @(posedge clk_sys);
      rawReq <= rq;
      @(posedge clk_sys);
      #1 chk(8'(fwd[2]), 8'(rq[2] & en[6]), "brownout gate");
      chk(8'(fwd[1]), 8'(rq[1] & en[5]), "pwm gate");
      chk(8'(fwd[0]), 8'(rq[0] & en[4]), "watchdog gate");
      @(posedge clk_sys);
      rawReq <= 3'h0;
      // zero bits written to status must not clear anything
      wr(SIE_ADDR_STATUS, 8'h8F);
      rd(SIE_ADDR_STATUS, rdv);
      chk(rdv, exp_status(en, rq), "status after pulse");
      chk(8'(irq), 8'(|(exp_status(en, rq) & msk)), "irq level");
      wr(SIE_ADDR_STATUS, 8'h70);
      rd(SIE_ADDR_STATUS, rdv);
      chk(rdv, 8'h00, "status cleared");
      chk(8'(irq), 8'h00, "irq after clear");
      chk(8'(fwd), 8'h00, "gates idle");
    end
    finish_test();
  end

endmodule : sie_bank_tb
